// ---- src/lfe_pkg.sv ----
package lfe_pkg;
   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int NI = 10;
   localparam int NIN = 8;
   localparam int NEQ = 16;
   localparam int DEP = 8;
   localparam int NFN = 22;
   localparam logic [3:0] BYTE_N = 4'h8;
   localparam logic [3:0] XOR_MIN = 4'h2;
   localparam logic [3:0] XOR_MAX = 4'ha;
   localparam logic [3:0] CNT_SAT = 4'hf;
   localparam logic [3:0] DEP_MAX = 4'h8;
   // ----------------------------------------
   // token kinds
   // ----------------------------------------
   localparam logic [3:0] TK_NONE = 4'h0;
   localparam logic [3:0] TK_FUNC = 4'h1;
   localparam logic [3:0] TK_OPEN = 4'h2;
   localparam logic [3:0] TK_CLOSE = 4'h3;
   localparam logic [3:0] TK_COMMA = 4'h4;
   localparam logic [3:0] TK_INT = 4'h5;
   localparam logic [3:0] TK_DEC = 4'h6;
   localparam logic [3:0] TK_SEMI = 4'h7;
   localparam logic [3:0] TK_BAD = 4'h8;
   localparam logic [3:0] TK_EOE = 4'h9;
   localparam logic [3:0] TK_EOA = 4'ha;
   // ----------------------------------------
   // checker message codes
   // ----------------------------------------
   localparam logic [3:0] E_NONE = 4'h0;
   localparam logic [3:0] E_MISS_SEMI = 4'h1;
   localparam logic [3:0] E_OPEN = 4'h2;
   localparam logic [3:0] E_CLOSE = 4'h3;
   localparam logic [3:0] E_COMMA = 4'h4;
   localparam logic [3:0] E_EMPTY = 4'h5;
   localparam logic [3:0] E_SEMI = 4'h6;
   localparam logic [3:0] E_FEW = 4'h7;
   localparam logic [3:0] E_SYNTAX = 4'h8;
   localparam logic [3:0] E_UNKNOWN = 4'h9;
   localparam logic [3:0] E_BAD_OPEN = 4'ha;
   localparam logic [3:0] E_MANY = 4'hb;
   localparam logic [3:0] E_NUMBER = 4'hc;
   localparam logic [3:0] E_PARAM = 4'hd;
   localparam logic [3:0] E_RES = 4'he;
   localparam logic [3:0] E_DONE = 4'hf;
   // ----------------------------------------
   // function table, index = function id
   // ----------------------------------------
   localparam logic [0:21][3:0] FN_REQ = {
      4'h2, 4'h2, 4'h3, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h2,
      4'h1, 4'h2, 4'h1, 4'h2, 4'h3, 4'h3, 4'h2, 4'h2, 4'h2, 4'h2, 4'h2};
   localparam logic [0:21][3:0] FN_MAX = {
      4'ha, 4'h2, 4'h3, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'ha,
      4'h1, 4'h2, 4'h1, 4'h2, 4'h4, 4'h4, 4'h2, 4'h2, 4'h2, 4'h2, 4'ha};
   // zero means no instance limit
   localparam logic [0:21][4:0] FN_LIM = {
      5'h00, 5'h0a, 5'h14, 5'h00, 5'h00, 5'h0a, 5'h00, 5'h00, 5'h00,
      5'h00, 5'h00, 5'h00, 5'h0a, 5'h0a, 5'h0a, 5'h0a, 5'h0a, 5'h0a,
      5'h0a, 5'h0a, 5'h0a, 5'h00};
   // bit p set: parameter p must be a literal integer
   localparam logic [0:21][15:0] FN_LIT = {
      16'h0000, 16'h0003, 16'h0004, 16'h0001, 16'h0001, 16'h0000,
      16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0001,
      16'h0003, 16'h0000, 16'h0000, 16'h0008, 16'h0008, 16'h0000,
      16'h0002, 16'h0002, 16'h0002, 16'h0000};
   typedef enum logic [2:0] {
      M_OOS = 3'b001,
      M_CHK = 3'b010,
      M_AUTO = 3'b100
   } mode_type;
endpackage : lfe_pkg

// ---- src/logic_function_evaluator.sv ----
//
// Function
// - pulse_count_divider asserts one strobe after divisor input pulses
// - rising edge primitive true only in false-to-true strobe
// - reset_priority_latch cleared by reset, else set latches true
// - left_shift_byte shifts toward top, data into bit 0
// - shift registers cleared while reset true; reset optional
// - right_shift_byte shifts toward bottom, data into bit 7
// - shift output is bit selected by index; 3 or 4 params
// - set_priority_latch forced true by set, follows set under reset
// - off_delay_timer holds true time x 100 ms after operand falls
// - on_delay_timer goes true time x 100 ms after operand rises
// - pulse_timer true for time x 100 ms on each rise while no pulse is running
// - xor of 2..10 operands false when all equal
// - at most ten instances per limited primitive (twenty for function id 2), else resource error
// - equation check runs on move to in-service
// - check in order, stop at first error, back to out_of_service_mode
// - report failing equation and message code
// - run-time bounds checks in service flag bad status
// - distinct terminator, bracket, comma, empty, early terminator errors
// - distinct too-few and too-many parameter errors
// - decimal number error and nested-result-for-literal error
// - unknown function, generic syntax, bracket after call close
// - all passed gives completion status
// - equation values held from previous strobe for later references
// - each equation result delivered as one boolean
module logic_function_evaluator (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic strobe_i,
   input wire logic tick_i,
   input wire logic [lfe_pkg::NIN-1:0] in_i,
   input wire logic [lfe_pkg::NI-1:0][2:0] ps_chan_i,
   input wire logic [lfe_pkg::NI-1:0][7:0] ps_div_i,
   output logic [lfe_pkg::NI-1:0] ps_q_o,
   output logic [lfe_pkg::NI-1:0] ps_bad_o,
   input wire logic [lfe_pkg::NI-1:0] rise_a_i,
   output logic [lfe_pkg::NI-1:0] rise_q_o,
   input wire logic [lfe_pkg::NI-1:0] rpl_set_i,
   input wire logic [lfe_pkg::NI-1:0] rpl_rst_i,
   output logic [lfe_pkg::NI-1:0] rpl_q_o,
   input wire logic [lfe_pkg::NI-1:0] spl_set_i,
   input wire logic [lfe_pkg::NI-1:0] spl_rst_i,
   output logic [lfe_pkg::NI-1:0] spl_q_o,
   input wire logic [lfe_pkg::NI-1:0] lsh_d_i,
   input wire logic [lfe_pkg::NI-1:0] lsh_clk_i,
   input wire logic [lfe_pkg::NI-1:0] lsh_rst_i,
   input wire logic [lfe_pkg::NI-1:0] lsh_rst_en_i,
   input wire logic [lfe_pkg::NI-1:0][3:0] lsh_bit_i,
   output logic [lfe_pkg::NI-1:0] lsh_q_o,
   output logic [lfe_pkg::NI-1:0] lsh_bad_o,
   input wire logic [lfe_pkg::NI-1:0] rsh_d_i,
   input wire logic [lfe_pkg::NI-1:0] rsh_clk_i,
   input wire logic [lfe_pkg::NI-1:0] rsh_rst_i,
   input wire logic [lfe_pkg::NI-1:0] rsh_rst_en_i,
   input wire logic [lfe_pkg::NI-1:0][3:0] rsh_bit_i,
   output logic [lfe_pkg::NI-1:0] rsh_q_o,
   output logic [lfe_pkg::NI-1:0] rsh_bad_o,
   input wire logic [lfe_pkg::NI-1:0] tof_a_i,
   input wire logic [lfe_pkg::NI-1:0][7:0] tof_t_i,
   output logic [lfe_pkg::NI-1:0] tof_q_o,
   input wire logic [lfe_pkg::NI-1:0] ton_a_i,
   input wire logic [lfe_pkg::NI-1:0][7:0] ton_t_i,
   output logic [lfe_pkg::NI-1:0] ton_q_o,
   input wire logic [lfe_pkg::NI-1:0] tp_a_i,
   input wire logic [lfe_pkg::NI-1:0][7:0] tp_t_i,
   output logic [lfe_pkg::NI-1:0] tp_q_o,
   input wire logic [lfe_pkg::NI-1:0] xor_a_i,
   input wire logic [3:0] xor_n_i,
   output logic xor_q_o,
   output logic xor_bad_o,
   input wire logic [lfe_pkg::NEQ-1:0] eq_val_i,
   output logic [lfe_pkg::NEQ-1:0] eq_out_o,
   input wire logic go_auto_i,
   input wire logic go_oos_i,
   input wire logic tok_valid_i,
   input wire logic [3:0] tok_kind_i,
   input wire logic [4:0] tok_fn_i,
   output logic tok_ready_o,
   output logic tgt_auto_o,
   output logic act_auto_o,
   output logic chk_done_o,
   output logic [3:0] chk_code_o,
   output logic [3:0] chk_eq_o
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [lfe_pkg::NIN-1:0] s1, s2, s3;
      logic tk;
      logic [lfe_pkg::NI-1:0] ps_q, ps_p, ps_bad;
      logic [lfe_pkg::NI-1:0][7:0] ps_c;
      logic [lfe_pkg::NI-1:0] ri_p, ri_q, rp_q, sp_q;
      logic [lfe_pkg::NI-1:0][7:0] ls_r, rs_r;
      logic [lfe_pkg::NI-1:0] ls_p, rs_p, ls_q, rs_q, ls_bad, rs_bad;
      logic [lfe_pkg::NI-1:0] tf_q, tn_q, tp_q, tp_p;
      logic [lfe_pkg::NI-1:0][7:0] tf_c, tn_c, tp_c;
      logic xq, xbad;
      logic [lfe_pkg::NEQ-1:0] eqv;
      lfe_pkg::mode_type md;
      logic [3:0] dep, last, code, eqn;
      logic [4:0] cfn;
      logic semi, done;
      logic [lfe_pkg::DEP-1:0][4:0] fstk;
      logic [lfe_pkg::DEP-1:0][3:0] cstk;
      logic [lfe_pkg::NFN-1:0][4:0] res;
   } st_type;

   st_type r_ff;
   st_type nxt_r;
   logic [lfe_pkg::NIN-1:0] edg;
   logic tk;
   logic hit;
   logic act;
   logic [lfe_pkg::NI-1:0] xm;
   logic [3:0] e;
   logic [2:0] top;
   logic [3:0] np;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_r = r_ff;
      hit = 1'b0;
      e = lfe_pkg::E_NONE;
      top = r_ff.dep[2:0] - 3'h1;
      np = r_ff.cstk[top] + 4'h1;
      // two flops before edge detect, inputs are asynchronous pins
      nxt_r.s1 = in_i;
      nxt_r.s2 = r_ff.s1;
      nxt_r.s3 = r_ff.s2;
      edg = r_ff.s2 & ~r_ff.s3;
      act = (r_ff.md == lfe_pkg::M_AUTO);
      // tick held until the next strobe so none is missed
      tk = r_ff.tk | tick_i;
      nxt_r.tk = tick_i | (r_ff.tk & ~strobe_i);
      for (int i = 0; i < lfe_pkg::NI; i++) begin
         // prescaler counts pin pulses every clock
         hit = 1'b0;
         if (ps_div_i[i] != '0 && edg[ps_chan_i[i]]) begin
            if (r_ff.ps_c[i] + 8'h01 == ps_div_i[i]) begin
               nxt_r.ps_c[i] = '0;
               hit = 1'b1;
            end else begin
               nxt_r.ps_c[i] = r_ff.ps_c[i] + 8'h01;
            end
         end
         nxt_r.ps_bad[i] = act & (ps_div_i[i] == '0);
         nxt_r.ls_bad[i] = act & (lsh_bit_i[i] >= lfe_pkg::BYTE_N);
         nxt_r.rs_bad[i] = act & (rsh_bit_i[i] >= lfe_pkg::BYTE_N);
         if (strobe_i) begin
            nxt_r.ps_q[i] = r_ff.ps_p[i];
            nxt_r.ps_p[i] = hit;
            nxt_r.ri_q[i] = rise_a_i[i] & ~r_ff.ri_p[i];
            nxt_r.ri_p[i] = rise_a_i[i];
            nxt_r.rp_q[i] = ~rpl_rst_i[i] & (rpl_set_i[i] | r_ff.rp_q[i]);
            nxt_r.sp_q[i] = spl_set_i[i] | (~spl_rst_i[i] & r_ff.sp_q[i]);
            nxt_r.ls_p[i] = lsh_clk_i[i];
            nxt_r.rs_p[i] = rsh_clk_i[i];
            if (lsh_rst_i[i] & lsh_rst_en_i[i]) begin
               nxt_r.ls_r[i] = '0;
            end else if (lsh_clk_i[i] & ~r_ff.ls_p[i]) begin
               nxt_r.ls_r[i] = {r_ff.ls_r[i][6:0], lsh_d_i[i]};
            end
            if (rsh_rst_i[i] & rsh_rst_en_i[i]) begin
               nxt_r.rs_r[i] = '0;
            end else if (rsh_clk_i[i] & ~r_ff.rs_p[i]) begin
               nxt_r.rs_r[i] = {rsh_d_i[i], r_ff.rs_r[i][7:1]};
            end
            nxt_r.ls_q[i] = (lsh_bit_i[i] < lfe_pkg::BYTE_N)
               & nxt_r.ls_r[i][lsh_bit_i[i][2:0]];
            nxt_r.rs_q[i] = (rsh_bit_i[i] < lfe_pkg::BYTE_N)
               & nxt_r.rs_r[i][rsh_bit_i[i][2:0]];
            // counters saturate at the set time, so no wrap back
            if (!ton_a_i[i]) begin
               nxt_r.tn_c[i] = '0;
               nxt_r.tn_q[i] = 1'b0;
            end else begin
               if (tk && r_ff.tn_c[i] < ton_t_i[i]) begin
                  nxt_r.tn_c[i] = r_ff.tn_c[i] + 8'h01;
               end
               nxt_r.tn_q[i] = (nxt_r.tn_c[i] >= ton_t_i[i]);
            end
            if (tof_a_i[i]) begin
               nxt_r.tf_c[i] = '0;
               nxt_r.tf_q[i] = 1'b1;
            end else begin
               if (tk && r_ff.tf_c[i] < tof_t_i[i]) begin
                  nxt_r.tf_c[i] = r_ff.tf_c[i] + 8'h01;
               end
               nxt_r.tf_q[i] = (nxt_r.tf_c[i] < tof_t_i[i]);
            end
            nxt_r.tp_p[i] = tp_a_i[i];
            // a rise during a running pulse does not restart it
            if (tp_a_i[i] & ~r_ff.tp_p[i] & ~r_ff.tp_q[i]) begin
               nxt_r.tp_c[i] = '0;
               nxt_r.tp_q[i] = 1'b1;
            end else if (r_ff.tp_q[i]) begin
               if (tk) begin
                  nxt_r.tp_c[i] = r_ff.tp_c[i] + 8'h01;
               end
               nxt_r.tp_q[i] = (nxt_r.tp_c[i] < tp_t_i[i]);
            end
         end else begin
            nxt_r.ps_p[i] = r_ff.ps_p[i] | hit;
         end
      end
      for (int j = 0; j < lfe_pkg::NI; j++) begin
         xm[j] = (4'(j) < xor_n_i);
      end
      nxt_r.xbad = act & ((xor_n_i < lfe_pkg::XOR_MIN) | (xor_n_i > lfe_pkg::XOR_MAX));
      if (strobe_i) begin
         nxt_r.xq = |(xor_a_i & xm) & ~&(xor_a_i | ~xm);
         nxt_r.eqv = eq_val_i;
      end
      // ----------------------------------------
      // mode and equation checker
      // ----------------------------------------
      nxt_r.done = 1'b0;
      if (go_oos_i) begin
         nxt_r.md = lfe_pkg::M_OOS;
      end else if (r_ff.md == lfe_pkg::M_OOS && go_auto_i) begin
         nxt_r.md = lfe_pkg::M_CHK;
         nxt_r.dep = '0;
         nxt_r.eqn = '0;
         nxt_r.semi = 1'b0;
         nxt_r.last = lfe_pkg::TK_NONE;
         nxt_r.res = '0;
         nxt_r.code = lfe_pkg::E_NONE;
      end else if (r_ff.md == lfe_pkg::M_CHK && tok_valid_i) begin
         nxt_r.last = tok_kind_i;
         if (r_ff.semi && tok_kind_i != lfe_pkg::TK_EOE
             && tok_kind_i != lfe_pkg::TK_EOA) begin
            e = lfe_pkg::E_SEMI;
         end else if (r_ff.last == lfe_pkg::TK_FUNC && tok_kind_i != lfe_pkg::TK_OPEN) begin
            e = lfe_pkg::E_SYNTAX;
         end else begin
            unique case (tok_kind_i)
               lfe_pkg::TK_FUNC: begin
                  nxt_r.cfn = tok_fn_i;
                  if (r_ff.last != lfe_pkg::TK_NONE && r_ff.last != lfe_pkg::TK_OPEN
                      && r_ff.last != lfe_pkg::TK_COMMA) begin
                     e = lfe_pkg::E_SYNTAX;
                  end else if (tok_fn_i >= 5'(lfe_pkg::NFN)) begin
                     e = lfe_pkg::E_UNKNOWN;
                  end else if (r_ff.dep != '0
                     && lfe_pkg::FN_LIT[r_ff.fstk[top]][r_ff.cstk[top]]) begin
                     e = lfe_pkg::E_PARAM;
                  end else if (lfe_pkg::FN_LIM[tok_fn_i] != '0
                     && r_ff.res[tok_fn_i] == lfe_pkg::FN_LIM[tok_fn_i]) begin
                     e = lfe_pkg::E_RES;
                  end else begin
                     nxt_r.res[tok_fn_i] = r_ff.res[tok_fn_i] + 5'h01;
                  end
               end
               lfe_pkg::TK_OPEN: begin
                  if (r_ff.last == lfe_pkg::TK_CLOSE) begin
                     e = lfe_pkg::E_BAD_OPEN;
                  end else if (r_ff.last != lfe_pkg::TK_FUNC
                     || r_ff.dep == lfe_pkg::DEP_MAX) begin
                     e = lfe_pkg::E_SYNTAX;
                  end else begin
                     nxt_r.fstk[r_ff.dep[2:0]] = r_ff.cfn;
                     nxt_r.cstk[r_ff.dep[2:0]] = '0;
                     nxt_r.dep = r_ff.dep + 4'h1;
                  end
               end
               lfe_pkg::TK_CLOSE: begin
                  if (r_ff.dep == '0) begin
                     e = lfe_pkg::E_CLOSE;
                  end else if (r_ff.last == lfe_pkg::TK_OPEN) begin
                     e = lfe_pkg::E_EMPTY;
                  end else if (r_ff.last == lfe_pkg::TK_COMMA) begin
                     e = lfe_pkg::E_COMMA;
                  end else if (np < lfe_pkg::FN_REQ[r_ff.fstk[top]]) begin
                     e = lfe_pkg::E_FEW;
                  end else if (np > lfe_pkg::FN_MAX[r_ff.fstk[top]]) begin
                     e = lfe_pkg::E_MANY;
                  end else begin
                     nxt_r.dep = r_ff.dep - 4'h1;
                  end
               end
               lfe_pkg::TK_COMMA: begin
                  if (r_ff.dep == '0) begin
                     e = lfe_pkg::E_SYNTAX;
                  end else if (r_ff.last == lfe_pkg::TK_OPEN
                     || r_ff.last == lfe_pkg::TK_COMMA) begin
                     e = lfe_pkg::E_COMMA;
                  end else if (r_ff.cstk[top] != lfe_pkg::CNT_SAT) begin
                     nxt_r.cstk[top] = np;
                  end
               end
               lfe_pkg::TK_INT, lfe_pkg::TK_DEC: begin
                  if (tok_kind_i == lfe_pkg::TK_DEC) begin
                     e = lfe_pkg::E_NUMBER;
                  end else if (r_ff.dep == '0 || (r_ff.last != lfe_pkg::TK_OPEN
                     && r_ff.last != lfe_pkg::TK_COMMA)
                     || !lfe_pkg::FN_LIT[r_ff.fstk[top]][r_ff.cstk[top]]) begin
                     e = lfe_pkg::E_SYNTAX;
                  end
               end
               lfe_pkg::TK_SEMI: begin
                  if (r_ff.dep != '0 || r_ff.last == lfe_pkg::TK_NONE) begin
                     e = lfe_pkg::E_SEMI;
                  end else begin
                     nxt_r.semi = 1'b1;
                  end
               end
               lfe_pkg::TK_EOE: begin
                  if (r_ff.dep != '0) begin
                     e = lfe_pkg::E_OPEN;
                  end else if (!r_ff.semi) begin
                     e = lfe_pkg::E_MISS_SEMI;
                  end else begin
                     nxt_r.eqn = r_ff.eqn + 4'h1;
                     nxt_r.semi = 1'b0;
                     nxt_r.last = lfe_pkg::TK_NONE;
                  end
               end
               lfe_pkg::TK_EOA: begin
                  nxt_r.md = lfe_pkg::M_AUTO;
                  nxt_r.code = lfe_pkg::E_DONE;
                  nxt_r.done = 1'b1;
               end
               default: begin
                  e = lfe_pkg::E_SYNTAX;
               end
            endcase
         end
         if (e != lfe_pkg::E_NONE) begin
            nxt_r.md = lfe_pkg::M_OOS;
            nxt_r.code = e;
            nxt_r.done = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         r_ff <= '0;
         r_ff.md <= lfe_pkg::M_OOS;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign ps_q_o = r_ff.ps_q;
   assign ps_bad_o = r_ff.ps_bad;
   assign rise_q_o = r_ff.ri_q;
   assign rpl_q_o = r_ff.rp_q;
   assign spl_q_o = r_ff.sp_q;
   assign lsh_q_o = r_ff.ls_q;
   assign lsh_bad_o = r_ff.ls_bad;
   assign rsh_q_o = r_ff.rs_q;
   assign rsh_bad_o = r_ff.rs_bad;
   assign tof_q_o = r_ff.tf_q;
   assign ton_q_o = r_ff.tn_q;
   assign tp_q_o = r_ff.tp_q;
   assign xor_q_o = r_ff.xq;
   assign xor_bad_o = r_ff.xbad;
   assign eq_out_o = r_ff.eqv;
   assign tok_ready_o = r_ff.md[1];
   assign tgt_auto_o = ~r_ff.md[0];
   assign act_auto_o = r_ff.md[2];
   assign chk_done_o = r_ff.done;
   assign chk_code_o = r_ff.code;
   assign chk_eq_o = r_ff.eqn;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_rise_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      strobe_i && rise_a_i[0] && !r_ff.ri_p[0] |=> rise_q_o[0])
      else $error("rise output missed");
   a_rise_level: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      strobe_i && r_ff.ri_p[0] |=> !rise_q_o[0])
      else $error("rise output not single");
   a_rpl_reset: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      strobe_i && rpl_rst_i[0] |=> !rpl_q_o[0])
      else $error("reset latch not cleared");
   a_spl_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      strobe_i && spl_set_i[0] |=> spl_q_o[0])
      else $error("set latch not set");
   a_lsh_move: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      strobe_i && lsh_clk_i[0] && !r_ff.ls_p[0] && !lsh_rst_i[0]
      |=> r_ff.ls_r[0] == {$past(r_ff.ls_r[0][6:0]), $past(lsh_d_i[0])})
      else $error("left shift wrong");
   a_xor_equal: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      strobe_i && (xor_a_i == '0 || xor_a_i == '1) |=> !xor_q_o)
      else $error("xor true on equal operands");
   a_ton_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      strobe_i && !ton_a_i[0] |=> !ton_q_o[0])
      else $error("on delay true while low");
   a_err_oos: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      chk_done_o && chk_code_o != lfe_pkg::E_DONE |-> !tgt_auto_o && !act_auto_o)
      else $error("error left mode in service");
   a_done_auto: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      chk_done_o && chk_code_o == lfe_pkg::E_DONE |-> act_auto_o ##1 !chk_done_o)
      else $error("completion without service");
endmodule : logic_function_evaluator

// ---- dv/host_model.sv ----
module host_model (
   input wire logic sys_clk_i,
   input wire logic tok_ready_i,
   output logic tok_valid_o,
   output logic [3:0] tok_kind_o,
   output logic [4:0] tok_fn_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      tok_valid_o = 1'b0;
      tok_kind_o = 4'h0;
      tok_fn_o = 5'h00;
   end
   // one token per edge, held until the edge that takes it
   task automatic send(input logic [3:0] k, input logic [4:0] f);
      @(negedge sys_clk_i);
      if (tok_ready_i !== 1'b1) begin
         // checker stopped at an error: later tokens are dropped
         tok_valid_o = 1'b0;
         return;
      end
      tok_valid_o = 1'b1;
      tok_kind_o = k;
      tok_fn_o = f;
      @(posedge sys_clk_i);
   endtask : send
   // released lines never keep showing the last token
   task automatic drop();
      @(negedge sys_clk_i);
      tok_valid_o = 1'b0;
      tok_kind_o = ~tok_kind_o;
      tok_fn_o = ~tok_fn_o;
   endtask : drop
   // one equation reading a device input, closed by end of equation
   task automatic eq_in();
      send(4'h1, 5'h08);
      send(4'h2, 5'h00);
      send(4'h5, 5'h00);
      send(4'h3, 5'h00);
      send(4'h7, 5'h00);
      send(4'h9, 5'h00);
   endtask : eq_in
endmodule : host_model

// ---- dv/tb.sv ----
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk_i, rst_i, strobe_i, tick_i, go_auto_i, go_oos_i, seen_done;
   logic [lfe_pkg::NIN-1:0] in_i;
   logic [lfe_pkg::NI-1:0][2:0] ps_chan_i;
   logic [lfe_pkg::NI-1:0][7:0] ps_div_i, tof_t_i, ton_t_i, tp_t_i;
   logic [lfe_pkg::NI-1:0][3:0] lsh_bit_i, rsh_bit_i;
   logic [lfe_pkg::NI-1:0] ps_q_o, ps_bad_o, rise_a_i, rise_q_o, rpl_set_i, rpl_rst_i;
   logic [lfe_pkg::NI-1:0] rpl_q_o, spl_set_i, spl_rst_i, spl_q_o, lsh_d_i, lsh_clk_i;
   logic [lfe_pkg::NI-1:0] lsh_rst_i, lsh_rst_en_i, lsh_q_o, lsh_bad_o, rsh_d_i, rsh_clk_i;
   logic [lfe_pkg::NI-1:0] rsh_rst_i, rsh_rst_en_i, rsh_q_o, rsh_bad_o, tof_a_i, tof_q_o;
   logic [lfe_pkg::NI-1:0] ton_a_i, ton_q_o, tp_a_i, tp_q_o, xor_a_i;
   logic [3:0] xor_n_i, tok_kind_i, chk_code_o, chk_eq_o;
   logic [4:0] tok_fn_i;
   logic xor_q_o, xor_bad_o, tok_valid_i, tok_ready_o, tgt_auto_o, act_auto_o, chk_done_o;
   logic [lfe_pkg::NEQ-1:0] eq_val_i, eq_out_o;
   int err_total, comparisons;
   logic_function_evaluator u_logic_function_evaluator (.sys_clk_i, .rst_i, .strobe_i,
      .tick_i, .in_i, .ps_chan_i, .ps_div_i, .ps_q_o, .ps_bad_o, .rise_a_i, .rise_q_o,
      .rpl_set_i, .rpl_rst_i, .rpl_q_o, .spl_set_i, .spl_rst_i, .spl_q_o, .lsh_d_i,
      .lsh_clk_i, .lsh_rst_i, .lsh_rst_en_i, .lsh_bit_i, .lsh_q_o, .lsh_bad_o, .rsh_d_i,
      .rsh_clk_i, .rsh_rst_i, .rsh_rst_en_i, .rsh_bit_i, .rsh_q_o, .rsh_bad_o, .tof_a_i,
      .tof_t_i, .tof_q_o, .ton_a_i, .ton_t_i, .ton_q_o, .tp_a_i, .tp_t_i, .tp_q_o, .xor_a_i,
      .xor_n_i, .xor_q_o, .xor_bad_o, .eq_val_i, .eq_out_o, .go_auto_i, .go_oos_i,
      .tok_valid_i, .tok_kind_i, .tok_fn_i, .tok_ready_o, .tgt_auto_o, .act_auto_o,
      .chk_done_o, .chk_code_o, .chk_eq_o);
   host_model u_host_model (.sys_clk_i, .tok_ready_i(tok_ready_o), .tok_valid_o(tok_valid_i),
      .tok_kind_o(tok_kind_i), .tok_fn_o(tok_fn_i));
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   // done is a one-cycle pulse: latch it so no wait can miss it
   always @(posedge sys_clk_i) if (chk_done_o === 1'b1) seen_done <= 1'b1;
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   task automatic step();
      @(negedge sys_clk_i) strobe_i = 1'b1;
      @(negedge sys_clk_i) strobe_i = 1'b0;
   endtask : step
   task automatic pulse(ref logic s);
      @(negedge sys_clk_i) s = 1'b1;
      @(negedge sys_clk_i) s = 1'b0;
   endtask : pulse
   task automatic t_prims();
      rise_a_i[0] = 1'b1; rpl_set_i[0] = 1'b1; spl_set_i[0] = 1'b1; spl_rst_i[0] = 1'b1;
      xor_n_i = 4'h3; xor_a_i = 10'h007; ton_a_i[0] = 1'b1; tof_a_i[0] = 1'b1;
      eq_val_i = 16'ha5c3;
      step();
      chk("rise", 16'h0001, 16'(rise_q_o[0]));
      chk("rpl", 16'h0001, 16'(rpl_q_o[0]));
      chk("spl", 16'h0001, 16'(spl_q_o[0]));
      chk("xor_eq", 16'h0000, 16'(xor_q_o));
      chk("ton", 16'h0001, 16'(ton_q_o[0]));
      chk("tof", 16'h0001, 16'(tof_q_o[0]));
      chk("eq_out", 16'ha5c3, eq_out_o);
      rpl_set_i[0] = 1'b0; spl_set_i[0] = 1'b0; xor_a_i = 10'h005;
      step();
      chk("rise_hold", 16'h0000, 16'(rise_q_o[0]));
      chk("rpl_hold", 16'h0001, 16'(rpl_q_o[0]));
      chk("spl_follow", 16'h0000, 16'(spl_q_o[0]));
      chk("xor_ne", 16'h0001, 16'(xor_q_o));
      rpl_set_i[0] = 1'b1; rpl_rst_i[0] = 1'b1;
      step();
      chk("rpl_rst", 16'h0000, 16'(rpl_q_o[0]));
   endtask : t_prims
   task automatic t_shift();
      lsh_rst_en_i[0] = 1'b1; lsh_rst_i[0] = 1'b1; lsh_d_i[0] = 1'b1; rsh_d_i[0] = 1'b1;
      step();
      lsh_rst_i[0] = 1'b0; lsh_clk_i[0] = 1'b1; rsh_clk_i[0] = 1'b1; rsh_bit_i[0] = 4'h7;
      step();
      chk("lsh_b0", 16'h0001, 16'(lsh_q_o[0]));
      chk("rsh_b7", 16'h0001, 16'(rsh_q_o[0]));
      lsh_clk_i[0] = 1'b0;
      step();
      lsh_clk_i[0] = 1'b1; lsh_d_i[0] = 1'b0; lsh_bit_i[0] = 4'h1;
      step();
      chk("lsh_b1", 16'h0001, 16'(lsh_q_o[0]));
      lsh_rst_i[0] = 1'b1;
      step();
      chk("lsh_clr", 16'h0000, 16'(lsh_q_o[0]));
   endtask : t_shift
   task automatic t_ps();
      ps_div_i[0] = 8'h02;
      repeat (4) @(negedge sys_clk_i) in_i[0] = ~in_i[0];
      repeat (3) @(negedge sys_clk_i);
      step();
      chk("ps", 16'h0001, 16'(ps_q_o[0]));
      step();
      chk("ps_once", 16'h0000, 16'(ps_q_o[0]));
   endtask : t_ps
   task automatic t_tmr();
      tp_t_i[0] = 8'h02; tp_a_i[0] = 1'b1; ton_t_i[1] = 8'h01; ton_a_i[1] = 1'b1;
      tof_t_i[0] = 8'h01; tof_a_i[0] = 1'b0;
      step();
      chk("tp_on", 16'h0001, 16'(tp_q_o[0]));
      chk("ton_wait", 16'h0000, 16'(ton_q_o[1]));
      chk("tof_hold", 16'h0001, 16'(tof_q_o[0]));
      pulse(tick_i);
      step();
      chk("ton_up", 16'h0001, 16'(ton_q_o[1]));
      chk("tp_hold", 16'h0001, 16'(tp_q_o[0]));
      chk("tof_off", 16'h0000, 16'(tof_q_o[0]));
      pulse(tick_i);
      step();
      chk("tp_end", 16'h0000, 16'(tp_q_o[0]));
   endtask : t_tmr
   task automatic wait_done();
      repeat (40) begin
         @(negedge sys_clk_i);
         if (seen_done === 1'b1) return;
      end
      err_total++;
      tally_and_finish();
   endtask : wait_done
   task automatic t_check(input logic bad);
      seen_done = 1'b0;
      rsh_bit_i[1] = 4'h8;
      pulse(go_auto_i);
      chk("tgt_auto", 16'h0001, 16'(tgt_auto_o));
      u_host_model.eq_in();
      if (bad) u_host_model.send(4'h1, 5'h16);
      if (bad) u_host_model.eq_in();
      u_host_model.send(4'ha, 5'h00);
      u_host_model.drop();
      wait_done();
      chk("code", bad ? 16'h0009 : 16'h000f, 16'(chk_code_o));
      if (bad) chk("eq_idx", 16'h0001, 16'(chk_eq_o));
      chk("tgt_after", 16'(!bad), 16'(tgt_auto_o));
      chk("act_auto", 16'(!bad), 16'(act_auto_o));
      chk("bad_flags", bad ? 16'h0000 : 16'h07fe,
         16'({xor_bad_o, lsh_bad_o[0], rsh_bad_o[1], ps_bad_o}));
      pulse(go_oos_i);
   endtask : t_check
   initial begin
      {rst_i, strobe_i, tick_i, go_auto_i, go_oos_i, seen_done, in_i, ps_chan_i} = '0;
      {ps_div_i, tof_t_i, ton_t_i, tp_t_i, lsh_bit_i, rsh_bit_i, rise_a_i} = '0;
      {rpl_set_i, rpl_rst_i, spl_set_i, spl_rst_i, lsh_d_i, lsh_clk_i, lsh_rst_i} = '0;
      {lsh_rst_en_i, rsh_d_i, rsh_clk_i, rsh_rst_i, rsh_rst_en_i, tof_a_i} = '0;
      {ton_a_i, tp_a_i, xor_a_i, xor_n_i, eq_val_i, err_total, comparisons} = '0;
      rst_i = 1'b1;
      repeat (16) @(negedge sys_clk_i);
      rst_i = 1'b0;
      t_prims();
      t_shift();
      t_ps();
      t_tmr();
      t_check(1'b0);
      t_check(1'b1);
      tally_and_finish();
   end
endmodule : tb
